// *** core/iscm_pkg.sv ***
// What this block does
// RULE_01 - Load, AND, OR, XOR on extended control block all interrupts three states.
// RULE_02 - Trace bit 7 set raises a trace exception after every executed instruction.
// RULE_03 - Extended control bits 6 to 3 always read one and reset to one.
// RULE_04 - Low three bits hold a writable mask level, resetting to seven.
// RULE_05 - Sense 00 requests an interrupt while line or alternate input is low.
// RULE_06 - Sense 01 requests an interrupt on each falling edge of either input.
// RULE_07 - Sense 10 requests an interrupt on each rising edge of either input.
// RULE_08 - Sense 11 requests an interrupt on both falling and rising edges.
// RULE_09 - Each upper line has its own writable high and low sense bits, reset zero.
// RULE_10 - Line 7 sits at bits 7:6 down to line 4 at bits 1:0.
package iscm_pkg;

  // Register byte offsets on the bus
  localparam logic [7:0] EXT_CTRL_OFS = 8'h00;
  localparam logic [7:0] SENSE_OFS = 8'h04;
  localparam logic [7:0] STATUS_OFS = 8'h08;
  localparam logic [7:0] MASK_OFS = 8'h0C;

  // Decoded register selectors
  localparam logic [2:0] SEL_EXT = 3'h0;
  localparam logic [2:0] SEL_SENSE = 3'h1;
  localparam logic [2:0] SEL_STATUS = 3'h2;
  localparam logic [2:0] SEL_MASK = 3'h3;
  localparam logic [2:0] SEL_NONE = 3'h4;

  // Extended control layout and reset values
  localparam int TRACE_POS = 7;
  localparam logic [7:0] EXT_RSVD_ONES = 8'h78;
  localparam logic TRACE_RST = 1'h0;
  localparam logic [2:0] LEVEL_RST = 3'h7;
  localparam logic [7:0] SENSE_RST = 8'h00;

  // Status layout: lines 4..7 at bits 0..3, trace at bit 4
  localparam int NUM_LINES = 4;
  localparam int STAT_W = 5;
  localparam int STAT_TRACE_POS = 4;
  localparam logic [STAT_W-1:0] STAT_RST = 5'h00;
  localparam logic [STAT_W-1:0] MASK_RST = 5'h00;

  // Interrupt blocking window after a control write, in states (cycles)
  localparam logic [1:0] BLOCK_STATES = 2'h3;

  // Bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    SENSE_LOW = 2'h0,
    SENSE_FALL = 2'h1,
    SENSE_RISE = 2'h2,
    SENSE_BOTH = 2'h3
  } iscm_sense_t;

  typedef enum logic [2:0] {
    OP_LOAD = 3'h0,
    OP_STORE = 3'h1,
    OP_AND = 3'h2,
    OP_OR = 3'h3,
    OP_XOR = 3'h4
  } iscm_op_t;

  // Control-register instruction from the CPU core, plus retire strobe
  typedef struct packed {
    logic valid;
    iscm_op_t op;
    logic [7:0] operand;
    logic retired;
  } iscm_instr_t;

endpackage

// *** core/iscm_top.sv ***
// Implementation choices: the address map and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
module iscm_top #(
  parameter int ADDR_W = 8
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire iscm_pkg::iscm_instr_t instr,
  output logic [7:0] store_data,
  input wire logic [iscm_pkg::NUM_LINES-1:0] external_request_line,
  input wire logic [iscm_pkg::NUM_LINES-1:0] alternate_request_input,
  output logic [iscm_pkg::NUM_LINES-1:0] line_request,
  output logic irq_block,
  output logic trace_exception,
  output logic [2:0] mask_level,
  output logic irq
);
  import iscm_pkg::*;

  // Offsets are compared on 8 bits, so a narrower bus cannot reach them
  if (ADDR_W < 8 || ADDR_W > 32) begin : g_bad_addr_w
    $error("iscm_top: ADDR_W must be 8 to 32");
  end

  typedef enum logic [1:0] {
    W_IDLE = 2'b01,
    W_RESP = 2'b10
  } iscm_wr_state_t;

  typedef enum logic [1:0] {
    R_IDLE = 2'b01,
    R_DATA = 2'b10
  } iscm_rd_state_t;

  // Map a byte address onto a register selector
  function automatic logic [2:0] decode_sel(input logic [ADDR_W-1:0] addr);
    logic [2:0] sel;
    sel = SEL_NONE;
    // Shift keeps the test legal when the bus is exactly 8 bits wide
    if ((addr >> 8) == '0) begin
      case (addr[7:0])
        EXT_CTRL_OFS: sel = SEL_EXT;
        SENSE_OFS: sel = SEL_SENSE;
        STATUS_OFS: sel = SEL_STATUS;
        MASK_OFS: sel = SEL_MASK;
        default: sel = SEL_NONE;
      endcase
    end
    return sel;
  endfunction

  iscm_wr_state_t wr_state;
  iscm_rd_state_t rd_state;
  logic aw_got;
  logic w_got;
  logic [ADDR_W-1:0] wr_addr;
  logic [7:0] wr_byte;
  logic wr_lane0;
  logic do_write;
  logic [2:0] wr_sel;
  logic [2:0] rd_sel;

  logic trace_bit;
  logic [2:0] level;
  logic [7:0] sense;
  logic [STAT_W-1:0] status;
  logic [STAT_W-1:0] mask;
  logic [7:0] ext_value;
  logic [7:0] next_ext;
  logic ctl_write;
  logic [1:0] block_cnt;
  logic block_now;

  logic [2*NUM_LINES-1:0] pin_s1;
  logic [2*NUM_LINES-1:0] pin_s2;
  logic [2*NUM_LINES-1:0] pin_s3;
  logic [2*NUM_LINES-1:0] pin_f;
  logic [NUM_LINES-1:0] line_lvl;
  logic [NUM_LINES-1:0] line_prev;
  logic [NUM_LINES-1:0] line_event;

  // Reserved bits are not stored, they are forced high on every read
  assign ext_value = {trace_bit, 4'h0, level} | EXT_RSVD_ONES;
  assign store_data = ext_value;
  assign mask_level = level;

  // Bus handshake
  assign awready = (wr_state == W_IDLE) && !aw_got;
  assign wready = (wr_state == W_IDLE) && !w_got;
  assign bvalid = (wr_state == W_RESP);
  assign arready = (rd_state == R_IDLE);
  assign rvalid = (rd_state == R_DATA);
  assign do_write = (wr_state == W_IDLE) && aw_got && w_got;
  assign wr_sel = decode_sel(wr_addr);
  assign rd_sel = decode_sel(araddr);

  // Address and data may arrive in either order
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      aw_got <= 1'b0;
      w_got <= 1'b0;
      wr_addr <= '0;
      wr_byte <= 8'h00;
      wr_lane0 <= 1'b0;
    end else begin
      if (awvalid && awready) begin
        aw_got <= 1'b1;
        wr_addr <= awaddr;
      end else if (do_write) begin
        aw_got <= 1'b0;
      end
      if (wvalid && wready) begin
        w_got <= 1'b1;
        wr_byte <= wdata[7:0];
        wr_lane0 <= wstrb[0];
      end else if (do_write) begin
        w_got <= 1'b0;
      end
    end
  end

  // Write response; unmapped addresses answer with an error
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wr_state <= W_IDLE;
      bresp <= RESP_OKAY;
    end else begin
      case (wr_state)
        W_IDLE: begin
          if (do_write) begin
            wr_state <= W_RESP;
            bresp <= (wr_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
          end
        end
        W_RESP: begin
          if (bready) begin
            wr_state <= W_IDLE;
          end
        end
        default: wr_state <= W_IDLE;
      endcase
    end
  end

  // Read path, data captured when the address is taken
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rd_state <= R_IDLE;
      rdata <= 32'h00000000;
      rresp <= RESP_OKAY;
    end else begin
      case (rd_state)
        R_IDLE: begin
          if (arvalid) begin
            rd_state <= R_DATA;
            rresp <= RESP_OKAY;
            case (rd_sel)
              // RULE_03 reserved read ones
              SEL_EXT: rdata <= {24'h000000, ext_value};
              SEL_SENSE: rdata <= {24'h000000, sense};
              SEL_STATUS: rdata <= {27'h0000000, status};
              SEL_MASK: rdata <= {27'h0000000, mask};
              default: begin
                rdata <= 32'h00000000;
                rresp <= RESP_SLVERR;
              end
            endcase
          end
        end
        R_DATA: begin
          if (rready) begin
            rd_state <= R_IDLE;
          end
        end
        default: rd_state <= R_IDLE;
      endcase
    end
  end

  // Next extended control value; the CPU instruction wins over a bus write
  always_comb begin
    next_ext = ext_value;
    ctl_write = 1'b0;
    if (instr.valid) begin
      case (instr.op)
        OP_LOAD: begin
          next_ext = instr.operand;
          ctl_write = 1'b1;
        end
        OP_AND: begin
          next_ext = ext_value & instr.operand;
          ctl_write = 1'b1;
        end
        OP_OR: begin
          next_ext = ext_value | instr.operand;
          ctl_write = 1'b1;
        end
        OP_XOR: begin
          next_ext = ext_value ^ instr.operand;
          ctl_write = 1'b1;
        end
        default: next_ext = ext_value;
      endcase
    end else if (do_write && wr_lane0 && wr_sel == SEL_EXT) begin
      // A bus write behaves as a load
      next_ext = wr_byte;
      ctl_write = 1'b1;
    end
  end

  // RULE_02 trace flag storage
  // RULE_04 mask level storage
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      trace_bit <= TRACE_RST;
      level <= LEVEL_RST;
    end else if (ctl_write) begin
      trace_bit <= next_ext[TRACE_POS];
      level <= next_ext[2:0];
    end
  end

  // RULE_01 three-state block window
  // Store does not qualify, so reading the register never delays interrupts
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      block_cnt <= 2'h0;
    end else if (ctl_write) begin
      block_cnt <= BLOCK_STATES;
    end else if (block_cnt != 2'h0) begin
      block_cnt <= block_cnt - 2'h1;
    end
  end

  assign irq_block = (block_cnt != 2'h0);
  assign block_now = irq_block || ctl_write;

  // RULE_09 sense register write
  // RULE_10 line 7 in the top pair
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sense <= SENSE_RST;
    end else if (do_write && wr_lane0 && wr_sel == SEL_SENSE) begin
      sense <= wr_byte;
    end
  end

  // Interrupt mask register
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      mask <= MASK_RST;
    end else if (do_write && wr_lane0 && wr_sel == SEL_MASK) begin
      mask <= wr_byte[STAT_W-1:0];
    end
  end

  // Pin synchronisers; a level counts once stages two and three agree
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pin_s1 <= 8'hFF;
      pin_s2 <= 8'hFF;
      pin_s3 <= 8'hFF;
      pin_f <= 8'hFF;
    end else begin
      pin_s1 <= {alternate_request_input, external_request_line};
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
      pin_f <= (pin_s2 ~^ pin_s3) & pin_s3 | ~(pin_s2 ~^ pin_s3) & pin_f;
    end
  end

  // Either input low pulls the line low
  assign line_lvl = pin_f[NUM_LINES-1:0] & pin_f[2*NUM_LINES-1:NUM_LINES];

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      line_prev <= {NUM_LINES{1'b1}};
    end else begin
      line_prev <= line_lvl;
    end
  end

  // Per-line sense selection, field i at bits 2i+1:2i
  genvar gi;
  generate
    for (gi = 0; gi < NUM_LINES; gi++) begin : g_line
      iscm_sense_t mode;
      logic fall;
      logic rise;
      assign mode = iscm_sense_t'(sense[2*gi+1:2*gi]);
      assign fall = line_prev[gi] && !line_lvl[gi];
      assign rise = !line_prev[gi] && line_lvl[gi];
      always_comb begin
        case (mode)
          // RULE_05 low level
          SENSE_LOW: line_event[gi] = !line_lvl[gi];
          // RULE_06 falling edge
          SENSE_FALL: line_event[gi] = fall;
          // RULE_07 rising edge
          SENSE_RISE: line_event[gi] = rise;
          // RULE_08 both edges
          SENSE_BOTH: line_event[gi] = fall || rise;
          default: line_event[gi] = 1'b0;
        endcase
      end
    end
  endgenerate

  // RULE_01 requests held off in window
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      line_request <= {NUM_LINES{1'b0}};
    end else begin
      line_request <= block_now ? {NUM_LINES{1'b0}} : line_event;
    end
  end

  // RULE_02 trace after each instruction
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      trace_exception <= 1'b0;
    end else begin
      trace_exception <= instr.retired && trace_bit;
    end
  end

  // Sticky status; a new event wins over a write-one clear
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      status <= STAT_RST;
    end else begin
      status <= (status & ~((do_write && wr_lane0 && wr_sel == SEL_STATUS) ? wr_byte[STAT_W-1:0] : 5'h00))
        | {instr.retired && trace_bit, line_event};
    end
  end

  // RULE_01 interrupt output gated
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      irq <= 1'b0;
    end else begin
      irq <= (|(status & mask)) && !block_now;
    end
  end

endmodule
`default_nettype wire

// *** tb/iscm_pins.sv ***
`timescale 1ns/1ps
`default_nettype none
module iscm_pins (
  input wire logic clk,
  input wire logic [3:0] low,
  input wire logic use_alt,
  output logic [3:0] ext,
  output logic [3:0] alt
);
  // either pin pulls low
  // Unused pin idles high, as if pulled up; reset covers the first edge
  always @(posedge clk) begin
    ext <= use_alt ? 4'hF : ~low;
    alt <= use_alt ? ~low : 4'hF;
  end
endmodule
`default_nettype wire

// *** tb/iscm_monitor.sv ***
`timescale 1ns/1ps
`default_nettype none
module iscm_monitor
  import iscm_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire iscm_pkg::iscm_instr_t instr,
  input wire logic awready,
  input wire logic wready,
  input wire logic irq_block,
  input wire logic irq,
  input wire logic [3:0] line_request,
  input wire logic [7:0] store_data,
  input wire logic [2:0] mask_level,
  input wire logic trace_exception,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic [31:0] rdata
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  // Window lasts at least three cycles, store exempt when no bus write is pending
  chk_block_len: assert property (
    instr.valid && instr.op != OP_STORE |=> irq_block [*3]) else $error("block window short");
  chk_store_free: assert property (
    instr.valid && instr.op == OP_STORE && awready && wready && !irq_block |=> !irq_block)
    else $error("store opened block");
  chk_block_gate: assert property (
    irq_block |-> !irq && line_request == 4'h0) else $error("request leaked in block");
  chk_trace_cause: assert property (
    trace_exception |-> $past(instr.retired) && $past(store_data[7])) else $error("stray trace");
  chk_trace_fire: assert property (
    instr.retired && store_data[7] && !instr.valid |=> trace_exception) else $error("trace missed");
  chk_rsvd_ones: assert property (
    store_data[6:3] == 4'hF) else $error("reserved bits not one");
  chk_level_out: assert property (
    mask_level == store_data[2:0]) else $error("level mismatch");
  chk_b_hold: assert property (bvalid && !bready |=> bvalid) else $error("bvalid dropped");
  chk_r_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata)) else $error("read dropped");
endmodule
`default_nettype wire

// *** tb/iscm_bench.sv ***
`timescale 1ns/1ps
`default_nettype none
module iscm_bench;
  import iscm_pkg::*;
  logic clk = 1'h0;
  logic sys_rst = 1'h1;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic awready, wready, bvalid, arready, rvalid, irq_block, trace_exception, irq;
  logic [1:0] bresp, rresp;
  logic [7:0] store_data;
  logic [2:0] mask_level;
  logic [3:0] line_request, ext_pin, alt_pin;
  logic [3:0] low = 4'h0;
  logic use_alt = 1'h0;
  iscm_instr_t instr = '0;
  int n_mismatch = 0, samples_checked = 0;
  iscm_top u_dut (.clk(clk), .sys_rst(sys_rst), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .instr(instr), .store_data(store_data), .external_request_line(ext_pin),
    .alternate_request_input(alt_pin), .line_request(line_request), .irq_block(irq_block),
    .trace_exception(trace_exception), .mask_level(mask_level), .irq(irq));
  iscm_pins u_pins (.clk(clk), .low(low), .use_alt(use_alt), .ext(ext_pin), .alt(alt_pin));
  // 40 MHz clock
  initial forever #12.5 clk = ~clk;
  task automatic end_of_test;
    $display("mismatches %0d of %0d checks", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // Ready is sampled between edges, so it is stable when the edge takes the item
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic pa, pw, ta, tw, b;
    logic [1:0] r;
    pa = 1'h1;
    pw = 1'h1;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do begin
      #1;
      ta = pa && awready;
      tw = pw && wready;
      b = bvalid;
      r = bresp;
      @(posedge clk);
      if (ta) begin
        pa = 1'h0;
        awvalid <= 1'h0;
      end
      if (tw) begin
        pw = 1'h0;
        wvalid <= 1'h0;
      end
    end while (!b);
    bready <= 1'h0;
    // Let an edge pass so a following call never re-raises bready in this step
    @(posedge clk);
    chk(32'(r), 32'(er));
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic t, v;
    logic [31:0] d;
    logic [1:0] r;
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do begin
      #1 t = arready;
      @(posedge clk);
    end while (!t);
    arvalid <= 1'h0;
    do begin
      #1 v = rvalid;
      d = rdata;
      r = rresp;
      @(posedge clk);
    end while (!v);
    rready <= 1'h0;
    @(posedge clk);
    chk(d, ed);
    chk(32'(r), 32'(er));
  endtask
  // One control instruction, then the block window cycle by cycle
  task automatic ins(input iscm_op_t o, input logic [7:0] v);
    instr <= {1'h1, o, v, 1'h0};
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      instr <= '0;
      #1 chk(32'(irq_block), 32'(i < 3 && o != OP_STORE));
    end
  endtask
  task automatic ret(input logic t);
    instr <= {1'h0, OP_LOAD, 8'h00, 1'h1};
    @(posedge clk);
    instr <= '0;
    #1 chk(32'(trace_exception), 32'(t));
  endtask
  task automatic t_reset;
    rd(EXT_CTRL_OFS, 32'h7F, RESP_OKAY);
    chk(32'(mask_level), 32'h7);
    rd(SENSE_OFS, 32'h0, RESP_OKAY);
    rd(8'h10, 32'h0, RESP_SLVERR);
    wr(8'h10, 32'h1, RESP_SLVERR);
  endtask
  task automatic t_ctrl;
    ins(OP_OR, 8'h80);
    ret(1'h1);
    ins(OP_AND, 8'h7A);
    chk(32'(mask_level), 32'h2);
    ret(1'h0);
    ins(OP_XOR, 8'h05);
    chk(32'(store_data), 32'h7F);
    ins(OP_LOAD, 8'h01);
    rd(EXT_CTRL_OFS, 32'h79, RESP_OKAY);
    ins(OP_STORE, 8'hFF);
    chk(32'(store_data), 32'h79);
    wr(EXT_CTRL_OFS, 32'h85, RESP_OKAY);
    rd(EXT_CTRL_OFS, 32'hFD, RESP_OKAY);
    ins(OP_LOAD, 8'h07);
  endtask
  // Line 4+m in mode m; odd lines driven on the alternate pin
  task automatic t_sense;
    logic [31:0] b;
    wr(STATUS_OFS, 32'h1F, RESP_OKAY);
    for (int m = 0; m < 4; m++) begin
      b = 32'h1 << m;
      use_alt <= m[0];
      wr(SENSE_OFS, 32'(m) << (2 * m), RESP_OKAY);
      rd(SENSE_OFS, 32'(m) << (2 * m), RESP_OKAY);
      low[m] <= 1'h1;
      repeat (8) @(posedge clk);
      // Level mode holds its request; edge pulses are long gone by now
      #1 chk(32'(line_request), m == 0 ? b : 32'h0);
      rd(STATUS_OFS, m == 2 ? 32'h0 : b, RESP_OKAY);
      wr(STATUS_OFS, 32'h1F, RESP_OKAY);
      rd(STATUS_OFS, m == 0 ? b : 32'h0, RESP_OKAY);
      low[m] <= 1'h0;
      repeat (8) @(posedge clk);
      #1 chk(32'(line_request), 32'h0);
      rd(STATUS_OFS, m == 1 ? 32'h0 : b, RESP_OKAY);
      wr(MASK_OFS, b, RESP_OKAY);
      @(posedge clk);
      #1 chk(32'(irq), 32'(m != 1));
      wr(MASK_OFS, 32'h0, RESP_OKAY);
      @(posedge clk);
      #1 chk(32'(irq), 32'h0);
      wr(STATUS_OFS, 32'h1F, RESP_OKAY);
      rd(STATUS_OFS, 32'h0, RESP_OKAY);
    end
  endtask
  // Four reset cycles, then the scenarios
  initial begin
    repeat (4) @(posedge clk);
    sys_rst <= 1'h0;
    t_reset;
    t_ctrl;
    t_sense;
    end_of_test;
  end
  // Run needs about 270 cycles
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    end_of_test;
  end
endmodule
bind iscm_top iscm_monitor u_mon (.clk(clk), .sys_rst(sys_rst), .instr(instr), .awready(awready),
  .wready(wready), .irq_block(irq_block), .irq(irq), .line_request(line_request), .store_data(store_data),
  .mask_level(mask_level), .trace_exception(trace_exception), .bvalid(bvalid), .bready(bready),
  .rvalid(rvalid), .rready(rready), .rdata(rdata));
`default_nettype wire
